// >>> rps_defines.vh
// rhythm pattern sequencer constants: widths, counter values, table word order
// assumes inclusion by rps_sequencer.v and by the bench
`ifndef RPS_DEFINES_VH
`define RPS_DEFINES_VH

`define RPS_APB_AW 8
`define RPS_CNT_W 6
`define RPS_BITS 64
`define RPS_NUM_SEL 9
`define RPS_NUM_VOICE 7
`define RPS_NUM_FEAT 4
`define RPS_NUM_LEN 5
`define RPS_COUNT_ONE 6'h00
`define RPS_COUNT_MAX 6'h3f

// reset-table word order: 0 fallback, 1 opt four, 2 opt three, 3 opt two, 4 opt one
`define RPS_LEN_FALLBACK 3'h0
`define RPS_LEN_OPT4 3'h1
`define RPS_LEN_OPT3 3'h2
`define RPS_LEN_OPT2 3'h3
`define RPS_LEN_OPT1 3'h4

// apb register byte offsets
`define RPS_REG_CTRL 8'h00
`define RPS_REG_STATUS 8'h04
`define RPS_REG_TBL_ADDR 8'h08
`define RPS_REG_TBL_DATA 8'h0c

// table address space, word index in tbl_addr[8:0]
// 0..62   voice table column: select*7+voice, 64 bits split lo/hi by tbl_addr[9]
// 64..68  reset table words (length condition 0..4)
// 80..99  feature table: feature*5+length condition
`define RPS_TBL_RESET_BASE 9'h040
`define RPS_TBL_FEAT_BASE 9'h050
`define RPS_NUM_VWORDS 63
`define RPS_NUM_FWORDS 20

// control register fields
`define RPS_CTRL_SW_RUN 0
`define RPS_CTRL_USE_SW 1

`endif

// >>> rps_sequencer.v
// rhythm pattern sequencer: halved clock, six-stage bit counter, reset,
// voice and feature tables loaded over apb.
// assumes: panel pins asynchronous to CLOCK, open-drain pads built outside.
//
// Overview of operation
// (R1) input clock is halved before the bit counter; a bit lasts two clocks
// (R2) run inactive holds halver and counter at count one, voices all off
// (R3) run asserted shows count one at once, then counter advances with clocks
// (R4) nine active-low pattern selects, any combination, voice patterns overlaid
// (R5) voice table 64 by 63: per count and select, which voices are on
// (R6) at most one length select low; none low means fallback condition
// (R7) each length condition may end the cycle at any bit 1 to 64
// (R8) reset word marks last bit and all later ones; cycle ends at first mark
// (R9) word one fallback, then opt four, three, two, word five opt one
// (R10) feature table 64 by 20, four outputs, one pattern per length condition
// (R11) seven voice outputs are open-drain sinks, on when the table selects
// (R12) loads must tolerate short decode glitches when the count changes
// (R13) unconnected control inputs read as not asserted
// (R14) after last bit the counter returns to count one and repeats
// (R15) outputs decode current count and current selects; changes apply at once
`timescale 1ns/1ps
`default_nettype none
`include "rps_defines.vh"

module rps_sequencer (
  input wire CLOCK,
  input wire RESET_N,
  input wire RHYTHM_CLK,
  input wire RUN_N,
  input wire [8:0] VOICE_PATTERN_SELECT_N,
  input wire LENGTH_OPT_ONE_N,
  input wire LENGTH_OPT_TWO_N,
  input wire LENGTH_OPT_THREE_N,
  input wire LENGTH_OPT_FOUR_N,
  output reg [6:0] VOICE_OUT,
  output reg [6:0] VOICE_OE,
  output reg [3:0] FEATURE_OUT,
  output reg [3:0] FEATURE_OE,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // run, select and length pins are active low and idle high, so the sync chain resets high;
  // an open pin then reads as released (see R13)
  localparam SYNC_W = 15;
  reg [SYNC_W-1:0] sync1_q;
  reg [SYNC_W-1:0] sync2_q;
  wire [SYNC_W-1:0] pins;
  assign pins = {RHYTHM_CLK, RUN_N, VOICE_PATTERN_SELECT_N, LENGTH_OPT_ONE_N,
                 LENGTH_OPT_TWO_N, LENGTH_OPT_THREE_N, LENGTH_OPT_FOUR_N};

  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1_q <= {SYNC_W{1'b1}};
      sync2_q <= {SYNC_W{1'b1}};
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  wire clk_s = sync2_q[14];
  wire run_pin_n = sync2_q[13];
  wire [8:0] sel_n = sync2_q[12:4];
  wire opt1_n = sync2_q[3];
  wire opt2_n = sync2_q[2];
  wire opt3_n = sync2_q[1];
  wire opt4_n = sync2_q[0];

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  reg [1:0] ctrl_q;
  reg [9:0] tbl_addr_q;
  reg [63:0] voice_tbl [0:`RPS_NUM_VWORDS-1];
  reg [63:0] feat_tbl [0:`RPS_NUM_FWORDS-1];
  reg [63:0] reset_tbl [0:`RPS_NUM_LEN-1];
  reg clk_q;
  reg half_q;
  reg [5:0] count_q;
  reg [2:0] len_sel;
  reg [2:0] len_q;

  wire apb_acc = PSEL && PENABLE && !PREADY;
  wire apb_wr = apb_acc && PWRITE;
  wire [8:0] widx = tbl_addr_q[8:0];
  wire whi = tbl_addr_q[9];

  // run when pin is low; when the use-sw bit is set, run follows the sw-run bit instead
  wire run = ctrl_q[`RPS_CTRL_USE_SW] ? ctrl_q[`RPS_CTRL_SW_RUN] : !run_pin_n;

  function [31:0] half_of;
    input [63:0] w;
    input hi;
    begin
      half_of = hi ? w[63:32] : w[31:0];
    end
  endfunction

  function [63:0] merge_half;
    input [63:0] w;
    input hi;
    input [31:0] d;
    begin
      merge_half = hi ? {d, w[31:0]} : {w[63:32], d};
    end
  endfunction

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `RPS_REG_CTRL) || (a == `RPS_REG_STATUS) ||
                (a == `RPS_REG_TBL_ADDR) || (a == `RPS_REG_TBL_DATA);
    end
  endfunction

  wire is_v = widx < `RPS_NUM_VWORDS;
  wire is_r = (widx >= `RPS_TBL_RESET_BASE) &&
              (widx < `RPS_TBL_RESET_BASE + `RPS_NUM_LEN);
  wire is_f = (widx >= `RPS_TBL_FEAT_BASE) &&
              (widx < `RPS_TBL_FEAT_BASE + `RPS_NUM_FWORDS);
  wire [8:0] r_off = widx - `RPS_TBL_RESET_BASE;
  wire [8:0] f_off = widx - `RPS_TBL_FEAT_BASE;

  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (PADDR)
      `RPS_REG_CTRL: rd_d = {30'h0, ctrl_q};
      `RPS_REG_STATUS: rd_d = {22'h0, len_q, half_q, count_q};
      `RPS_REG_TBL_ADDR: rd_d = {22'h0, tbl_addr_q};
      `RPS_REG_TBL_DATA: begin
        if (is_v)
          rd_d = half_of(voice_tbl[widx[5:0]], whi);
        else if (is_r)
          rd_d = half_of(reset_tbl[r_off[2:0]], whi);
        else if (is_f)
          rd_d = half_of(feat_tbl[f_off[4:0]], whi);
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // one wait state: pready rises after the first access cycle, done next edge
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      ctrl_q <= 2'h0;
      tbl_addr_q <= 10'h000;
    end else begin
      PREADY <= apb_acc;
      PSLVERR <= apb_acc && !addr_ok(PADDR);
      if (apb_acc && !PWRITE)
        PRDATA <= rd_d;
      if (apb_wr && PADDR == `RPS_REG_CTRL)
        ctrl_q <= PWDATA[1:0];
      if (apb_wr && PADDR == `RPS_REG_TBL_ADDR)
        tbl_addr_q <= PWDATA[9:0];
    end
  end

  // table storage has no reset: software loads it before running
  always @(posedge CLOCK) begin
    if (apb_wr && PADDR == `RPS_REG_TBL_DATA) begin
      if (is_v)
        voice_tbl[widx[5:0]] <= merge_half(voice_tbl[widx[5:0]], whi, PWDATA);
      if (is_r)
        reset_tbl[r_off[2:0]] <= merge_half(reset_tbl[r_off[2:0]], whi, PWDATA);
      if (is_f)
        feat_tbl[f_off[4:0]] <= merge_half(feat_tbl[f_off[4:0]], whi, PWDATA);
    end
  end

  // ----------------------------------------------------------------
  // length condition
  // ----------------------------------------------------------------
  // more than one select low is outside the contract; lowest word wins
  always @* begin
    if (!opt4_n)
      len_sel = `RPS_LEN_OPT4; // see (R6) (R9)
    else if (!opt3_n)
      len_sel = `RPS_LEN_OPT3;
    else if (!opt2_n)
      len_sel = `RPS_LEN_OPT2;
    else if (!opt1_n)
      len_sel = `RPS_LEN_OPT1;
    else
      len_sel = `RPS_LEN_FALLBACK; // see (R6)
  end

  // ----------------------------------------------------------------
  // halver and bit counter
  // ----------------------------------------------------------------
  wire clk_rise = clk_s && !clk_q;
  wire [63:0] rst_word = reset_tbl[len_sel];
  // the first marked bit ends the cycle; later marks are don't-care
  wire last_bit = rst_word[count_q]; // see (R7) (R8)

  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      clk_q <= 1'b1;
      half_q <= 1'b0;
      count_q <= `RPS_COUNT_ONE;
      len_q <= `RPS_LEN_FALLBACK;
    end else begin
      clk_q <= clk_s;
      len_q <= len_sel;
      if (!run) begin
        half_q <= 1'b0; // see (R2)
        count_q <= `RPS_COUNT_ONE;
      end else if (clk_rise) begin
        half_q <= !half_q; // see (R1)
        if (half_q) begin
          if (last_bit || count_q == `RPS_COUNT_MAX)
            count_q <= `RPS_COUNT_ONE; // see (R14)
          else
            count_q <= count_q + 6'h01; // see (R3)
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // voice and feature decode
  // ----------------------------------------------------------------
  // decoded straight from count and live selects, one register stage to pins;
  // glitch-free here, but loads still follow the short-spike allowance (R12)
  reg [6:0] voice_d;
  reg [3:0] feat_d;
  wire [62:0] vbit;
  wire [19:0] fbit;

  genvar g;
  generate
    for (g = 0; g < `RPS_NUM_VWORDS; g = g + 1) begin : g_v
      assign vbit[g] = voice_tbl[g][count_q]; // see (R5)
    end
    for (g = 0; g < `RPS_NUM_FWORDS; g = g + 1) begin : g_f
      assign fbit[g] = feat_tbl[g][count_q]; // see (R10)
    end
  endgenerate

  integer s;
  integer v;
  always @* begin
    voice_d = 7'h00;
    feat_d = 4'h0;
    for (s = 0; s < `RPS_NUM_SEL; s = s + 1)
      for (v = 0; v < `RPS_NUM_VOICE; v = v + 1)
        if (!sel_n[s] && vbit[s*`RPS_NUM_VOICE+v])
          voice_d[v] = 1'b1; // see (R4) (R15)
    for (v = 0; v < `RPS_NUM_FEAT; v = v + 1)
      feat_d[v] = fbit[v*`RPS_NUM_LEN+len_sel]; // see (R10) (R15)
    if (!run)
      voice_d = 7'h00; // see (R2)
  end

  // open-drain: output pin value fixed low, enable sinks
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      VOICE_OUT <= 7'h00;
      VOICE_OE <= 7'h00;
      FEATURE_OUT <= 4'h0;
      FEATURE_OE <= 4'h0;
    end else begin
      VOICE_OUT <= 7'h00;
      VOICE_OE <= voice_d; // see (R11)
      FEATURE_OUT <= 4'h0;
      FEATURE_OE <= feat_d;
    end
  end

endmodule
`default_nettype wire

// >>> rps_sequencer_sva.sv
// checker: apb handshake, open-drain data and run gating of the sequencer
// assumes binding onto rps_sequencer with its port names
`timescale 1ns/1ps
`default_nettype none
module rps_seq_sva (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic RUN_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [6:0] VOICE_OUT,
  input wire logic [6:0] VOICE_OE,
  input wire logic [3:0] FEATURE_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // ---
  // properties
  // ---
  run_gate_a: assert property (RUN_N [*6] |-> VOICE_OE == 7'h00)
    else $error("voice on while run is off");
  voice_drain_a: assert property (VOICE_OUT == 7'h00)
    else $error("voice data not low");
  feat_drain_a: assert property (FEATURE_OUT == 4'h0)
    else $error("feature data not low");
  ready_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (PREADY |-> $past(PSEL) && $past(PENABLE))
    else $error("ready without access");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  unmapped_err_a: assert property (PREADY && PADDR[7:4] != 4'h0 |-> PSLVERR)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (PREADY && PADDR[7:4] == 4'h0 |-> !PSLVERR)
    else $error("mapped access refused");
  cover property (PSLVERR);
  cover property (VOICE_OE != 7'h00);
  cover property ($fell(RUN_N));
endmodule
bind rps_sequencer rps_seq_sva u_sva (.*);
`default_nettype wire

// >>> rps_panel.sv
// far side: rhythm clock source and pulled-up voice sink lines
// assumes the bench clock; rhythm clock idles low between bursts
`timescale 1ns/1ps
`default_nettype none
module rps_panel (
  input wire logic CLOCK,
  input wire logic [6:0] voice_oe,
  output logic rhythm_clk,
  output logic [6:0] voice_n
);
  // ---
  // lines and clock
  // ---
  // load resistor pulls a line up unless sunk
  assign voice_n = ~voice_oe;
  initial rhythm_clk = 1'b0;
  // phases of four clocks clear the two-flop synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge CLOCK);
      rhythm_clk <= 1'b1;
      repeat (4) @(posedge CLOCK);
      rhythm_clk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> rps_sequencer_tb_top.sv
// bench: table load over apb, run gating, halving, lengths, selects
// assumes design, panel model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "rps_defines.vh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module rps_sequencer_tb_top;
  logic CLOCK = 1'b0, RESET_N = 1'b0, RUN_N = 1'b1;
  logic LENGTH_OPT_ONE_N = 1'b1, LENGTH_OPT_FOUR_N = 1'b1;
  logic LENGTH_OPT_TWO_N = 1'b1, LENGTH_OPT_THREE_N = 1'b1;
  logic [8:0] VOICE_PATTERN_SELECT_N = 9'h1fc;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, err;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, rd;
  wire RHYTHM_CLK, PREADY, PSLVERR;
  wire [31:0] PRDATA;
  wire [6:0] VOICE_OUT, VOICE_OE, voice_n;
  wire [3:0] FEATURE_OUT, FEATURE_OE;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  rps_sequencer DUT (.*);
  rps_panel panel (.CLOCK(CLOCK), .voice_oe(VOICE_OE), .rhythm_clk(RHYTHM_CLK),
    .voice_n(voice_n));
  always #20 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      end_of_test();
    end
  end
  // ---
  // tasks
  // ---
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1 && ++n < 50);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic tbl(input logic [8:0] i, input logic [63:0] w);
    apb(1'b1, `RPS_REG_TBL_ADDR, {23'h0, i});
    apb(1'b1, `RPS_REG_TBL_DATA, w[31:0]);
    apb(1'b1, `RPS_REG_TBL_ADDR, {22'h0, 1'b1, i});
    apb(1'b1, `RPS_REG_TBL_DATA, w[63:32]);
  endtask
  task automatic status();
    apb(1'b0, `RPS_REG_STATUS, 32'h0);
  endtask
  task automatic restart();
    RUN_N <= 1'b1;
    repeat (8) @(posedge CLOCK);
    RUN_N <= 1'b0;
    repeat (6) @(posedge CLOCK);
  endtask
  task end_of_test();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ---
  // sequence
  // ---
  initial begin
    repeat (3) @(posedge CLOCK);
    RESET_N <= 1'b1;
    status();
    `CHK("count", 6'h00, rd[5:0])
    `CHK("cond", `RPS_LEN_FALLBACK, rd[9:7])
    tbl(9'h000, 64'h1);
    tbl(9'h008, 64'h3);
    tbl(`RPS_TBL_RESET_BASE, 64'hffff_ffff_ffff_fff8);
    tbl(`RPS_TBL_RESET_BASE + 9'h1, 64'h8000_0000_0000_0000);
    tbl(`RPS_TBL_RESET_BASE + 9'h4, 64'hffff_ffff_ffff_fffe);
    tbl(`RPS_TBL_RESET_BASE + 9'h3, 64'hffff_ffff_ffff_fffc);
    tbl(`RPS_TBL_RESET_BASE + 9'h2, 64'hffff_ffff_ffff_ffff);
    tbl(`RPS_TBL_FEAT_BASE, 64'h1);
    tbl(`RPS_TBL_FEAT_BASE + 9'h4, 64'h4);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("rdata", 32'h0, rd)
    panel.pulse(4);
    status();
    `CHK("held", 6'h00, rd[5:0])
    RUN_N <= 1'b0;
    repeat (6) @(posedge CLOCK);
    `CHK("overlay", 7'h03, VOICE_OE)
    `CHK("sink", 7'h7c, voice_n)
    `CHK("feat", 1'b1, FEATURE_OE[0])
    panel.pulse(1);
    status();
    `CHK("half", 6'h00, rd[5:0])
    panel.pulse(1);
    repeat (6) @(posedge CLOCK);
    `CHK("voice2", 7'h02, VOICE_OE)
    VOICE_PATTERN_SELECT_N <= 9'h1fe;
    repeat (6) @(posedge CLOCK);
    `CHK("desel", 7'h00, VOICE_OE)
    VOICE_PATTERN_SELECT_N <= 9'h1fc;
    for (int k = 2; k < 8; k++) begin
      panel.pulse(2);
      status();
      `CHK("wrap", 6'(k % 4), rd[5:0])
    end
    LENGTH_OPT_ONE_N <= 1'b0;
    restart();
    `CHK("fsel", 1'b0, FEATURE_OE[0])
    status();
    `CHK("cond1", `RPS_LEN_OPT1, rd[9:7])
    for (int k = 1; k < 4; k++) begin
      panel.pulse(2);
      status();
      `CHK("len2", 6'(k % 2), rd[5:0])
    end
    LENGTH_OPT_ONE_N <= 1'b1;
    LENGTH_OPT_FOUR_N <= 1'b0;
    restart();
    panel.pulse(126);
    status();
    `CHK("last", 6'h3f, rd[5:0])
    `CHK("cond4", `RPS_LEN_OPT4, rd[9:7])
    panel.pulse(2);
    status();
    `CHK("wrap64", 6'h00, rd[5:0])
    LENGTH_OPT_FOUR_N <= 1'b1;
    LENGTH_OPT_TWO_N <= 1'b0;
    restart();
    status();
    `CHK("cond2", `RPS_LEN_OPT2, rd[9:7])
    panel.pulse(2);
    status();
    `CHK("len3", 6'h01, rd[5:0])
    LENGTH_OPT_TWO_N <= 1'b1;
    LENGTH_OPT_THREE_N <= 1'b0;
    restart();
    status();
    `CHK("cond3", `RPS_LEN_OPT3, rd[9:7])
    panel.pulse(2);
    status();
    `CHK("len1", 6'h00, rd[5:0])
    LENGTH_OPT_THREE_N <= 1'b1;
    restart();
    apb(1'b1, `RPS_REG_CTRL, 32'h2);
    panel.pulse(4);
    status();
    `CHK("swhold", 6'h00, rd[5:0])
    apb(1'b1, `RPS_REG_CTRL, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
